// *** logic/eim_index_mode.sv ***
`timescale 1ns/1ps
// Function
// RULE1 - command 54h enters temporary index mode, line low until mark seen
// RULE2 - line driven low about 6 ms after either index command
// RULE3 - in index mode line is high while on mark, low otherwise
// RULE4 - temporary mode holds line low 5 ms after leaving mark
// RULE5 - then return to serial command mode and accept commands again
// RULE6 - command 5Fh enters permanent index mode showing mark on line
// RULE7 - permanent mode lasts until power loss; reset returns serial mode
// RULE8 - no command decoding or answers while any index mode is active
module eim_index_mode #(
  parameter int START_CYCLES = eim_pkg::START_CYCLES,
  parameter int TAIL_CYCLES = eim_pkg::TAIL_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic cmd_valid_in,
  input wire logic index_mark_in,
  input wire logic serial_data_in,
  input wire logic serial_oe_in,
  output logic cmd_accept_out,
  output logic line_data_out,
  output logic line_oe_out,
  output logic index_mode_out,
  output logic serial_mode_out
);
  eim_sync_if mark_if ();
  eim_pkg::eim_state_t state_r;
  eim_pkg::eim_state_t state_nxt;
  logic perm_pend_r;
  logic [eim_pkg::CNT_W-1:0] cnt_r;
  logic line_r;
  logic oe_r;
  logic hit_temp;
  logic hit_perm;

  // the counter width caps both delays at 2**CNT_W cycles; the defaults need 18 bits
  // true on the last cycle of a delay of the given length
  function automatic logic cnt_done(input logic [eim_pkg::CNT_W-1:0] cnt, input int cycles);
    return cnt == eim_pkg::CNT_W'(cycles - 1);
  endfunction : cnt_done

  // one decoder for both index commands, so their gating can never drift apart
  function automatic logic code_hit(input logic valid, input logic gate, input logic [7:0] code,
                                    input logic [7:0] want);
    return valid && gate && (code == want);
  endfunction : code_hit

  // mark level after the three-flop agreement filter
  eim_mark_sync u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .raw_in(index_mark_in),
    .sync(mark_if.src)
  );

  // commands are only decoded in serial mode
  assign cmd_accept_out = (state_r == eim_pkg::EIM_SERIAL); // [RULE8]
  assign hit_temp = code_hit(cmd_valid_in, cmd_accept_out, cmd_code_in, eim_pkg::CMD_IDX_TEMP); // [RULE1]
  assign hit_perm = code_hit(cmd_valid_in, cmd_accept_out, cmd_code_in, eim_pkg::CMD_IDX_PERM); // [RULE6]

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      eim_pkg::EIM_SERIAL: begin
        if (hit_temp || hit_perm) begin
          state_nxt = eim_pkg::EIM_WAIT;
        end
      end
      eim_pkg::EIM_WAIT: begin
        // commands arriving now are refused by cmd_accept_out, not queued
        if (cnt_done(cnt_r, START_CYCLES)) begin // [RULE2]
          state_nxt = perm_pend_r ? eim_pkg::EIM_PERM : eim_pkg::EIM_TEMP_WAIT_MARK;
        end
      end
      eim_pkg::EIM_TEMP_WAIT_MARK: begin
        if (mark_if.mark) begin
          state_nxt = eim_pkg::EIM_TEMP_MARK;
        end
      end
      eim_pkg::EIM_TEMP_MARK: begin
        if (!mark_if.mark) begin
          state_nxt = eim_pkg::EIM_TEMP_TAIL;
        end
      end
      eim_pkg::EIM_TEMP_TAIL: begin
        if (cnt_done(cnt_r, TAIL_CYCLES)) begin // [RULE4]
          state_nxt = eim_pkg::EIM_SERIAL; // [RULE5]
        end
      end
      eim_pkg::EIM_PERM: begin
        state_nxt = eim_pkg::EIM_PERM; // only reset (power) leaves it [RULE7]
      end
      // a corrupt state code falls back to serial, the safe owner of the line
      default: begin
        state_nxt = eim_pkg::EIM_SERIAL;
      end
    endcase
  end

  // state register; reset stands in for power-up
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= eim_pkg::EIM_SERIAL; // [RULE7]
    end else begin
      state_r <= state_nxt;
    end
  end

  // remembers which command started the delay
  // a refused command cannot reach here, since both hits need cmd_accept_out
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      perm_pend_r <= 1'b0;
    end else if (hit_temp || hit_perm) begin
      perm_pend_r <= hit_perm;
    end
  end

  // delay counter restarts on every state change
  // it holds still in the other states; only the two delays read it
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (state_r == eim_pkg::EIM_WAIT || state_r == eim_pkg::EIM_TEMP_TAIL) begin
      cnt_r <= cnt_r + eim_pkg::CNT_W'(1);
    end
  end

  // line drive: serial side owns it in serial mode, index logic otherwise
  // keyed on state_nxt so the line changes on the same edge as the state
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      line_r <= eim_pkg::LINE_RESET;
      oe_r <= 1'b0;
    end else begin
      case (state_nxt)
        eim_pkg::EIM_SERIAL: begin
          line_r <= serial_data_in;
          oe_r <= serial_oe_in;
        end
        eim_pkg::EIM_WAIT: begin
          line_r <= serial_data_in; // nothing forced yet during the start delay
          oe_r <= 1'b0; // no replies during start delay [RULE2]
        end
        eim_pkg::EIM_TEMP_TAIL: begin
          line_r <= 1'b0; // [RULE4]
          oe_r <= 1'b1;
        end
        default: begin
          line_r <= mark_if.mark; // [RULE3]
          oe_r <= 1'b1; // [RULE1]
        end
      endcase
    end
  end

  assign line_data_out = line_r;
  assign line_oe_out = oe_r;
  assign index_mode_out = (state_r != eim_pkg::EIM_SERIAL);
  assign serial_mode_out = (state_r == eim_pkg::EIM_SERIAL);

  // a decoded index command enters the start delay with the line released
  start_delay_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE2]
    (state_r == eim_pkg::EIM_SERIAL && (hit_temp || hit_perm)) |=> !line_oe_out ##0
    (state_r == eim_pkg::EIM_WAIT)) else $error("start delay not entered");
  no_decode_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE8]
    index_mode_out |-> !cmd_accept_out && !hit_temp && !hit_perm) else $error("command accepted in index mode");
  mark_high_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE3]
    (state_r == eim_pkg::EIM_PERM && $past(state_r) == eim_pkg::EIM_PERM) |=>
    (line_data_out == $past(mark_if.mark)) && line_oe_out) else $error("line does not follow mark");
  perm_stays_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE7]
    (state_r == eim_pkg::EIM_PERM) |=> (state_r == eim_pkg::EIM_PERM)) else $error("permanent mode left");
  tail_low_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE4]
    (state_r == eim_pkg::EIM_TEMP_TAIL) |-> (line_data_out == 1'b0) && line_oe_out)
    else $error("tail not driven low");
  tail_ends_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE5]
    (state_r == eim_pkg::EIM_TEMP_TAIL && cnt_r == eim_pkg::CNT_W'(TAIL_CYCLES - 1)) |=> serial_mode_out)
    else $error("no return to serial");
  temp_entry_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE1]
    (state_r == eim_pkg::EIM_WAIT && !perm_pend_r && cnt_r == eim_pkg::CNT_W'(START_CYCLES - 1)) |=>
    (state_r == eim_pkg::EIM_TEMP_WAIT_MARK)) else $error("temporary mode not entered");
  perm_entry_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE6]
    (state_r == eim_pkg::EIM_WAIT && perm_pend_r && cnt_r == eim_pkg::CNT_W'(START_CYCLES - 1)) |=>
    (state_r == eim_pkg::EIM_PERM) ##1 line_oe_out) else $error("permanent mode not entered");

  // further checks on each phase of the mode logic
  // refused commands must not change which mode the delay ends in
  refused_keep_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE8]
    (index_mode_out && cmd_valid_in) |=> $stable(perm_pend_r)) else $error("refused command changed mode");
  // the line is released for the whole start delay, which never overruns its count
  wait_release_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE2]
    (state_r == eim_pkg::EIM_WAIT) |-> !line_oe_out && (cnt_r < eim_pkg::CNT_W'(START_CYCLES)))
    else $error("line driven in start delay");
  // only the two index codes leave serial mode
  other_codes_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE1]
    (serial_mode_out && !hit_temp && !hit_perm) |=> serial_mode_out)
    else $error("serial mode left without command");
  // before the mark the temporary mode holds the line low
  wait_low_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE1]
    (state_r == eim_pkg::EIM_TEMP_WAIT_MARK && $past(state_r) == eim_pkg::EIM_TEMP_WAIT_MARK) |->
    !line_data_out && line_oe_out) else $error("line not low before mark");
  // a seen mark raises the line on the next edge
  mark_rise_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE3]
    (state_r == eim_pkg::EIM_TEMP_WAIT_MARK && mark_if.mark) |=>
    (state_r == eim_pkg::EIM_TEMP_MARK) && line_data_out) else $error("mark not shown on line");
  // on the mark the line stays high
  temp_high_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE3]
    (state_r == eim_pkg::EIM_TEMP_MARK) |-> line_data_out && line_oe_out) else $error("line low on mark");
  // permanent mode always drives the line
  perm_drive_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE6]
    (state_r == eim_pkg::EIM_PERM) |-> line_oe_out && index_mode_out)
    else $error("line released in permanent mode");
  // the tail never outlasts its count
  tail_bound_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE4]
    (state_r == eim_pkg::EIM_TEMP_TAIL) |-> (cnt_r < eim_pkg::CNT_W'(TAIL_CYCLES))) else $error("tail overran");
  // in serial mode the line repeats the transmitter one cycle later
  serial_follow_a: assert property (@(posedge clock_in) disable iff (reset_in) // [RULE5]
    (state_nxt == eim_pkg::EIM_SERIAL) |=> (line_data_out == $past(serial_data_in)) &&
    (line_oe_out == $past(serial_oe_in))) else $error("line does not follow serial side");
endmodule : eim_index_mode

// *** logic/eim_pkg.sv ***
package eim_pkg;
  // command codes that switch the data line into index output
  localparam logic [7:0] CMD_IDX_TEMP = 8'h54;
  localparam logic [7:0] CMD_IDX_PERM = 8'h5f;
  // clock rate and documented delays
  localparam int CLK_HZ = 40000000;
  localparam int START_DELAY_US = 6000;
  localparam int TAIL_DELAY_US = 5000;
  localparam int START_CYCLES = (START_DELAY_US / 1000) * (CLK_HZ / 1000);
  localparam int TAIL_CYCLES = (TAIL_DELAY_US / 1000) * (CLK_HZ / 1000);
  localparam int CNT_W = 24;
  // line output value after reset: released, serial mode
  localparam logic LINE_RESET = 1'b0;
  typedef enum logic [2:0] {EIM_SERIAL, EIM_WAIT, EIM_TEMP_WAIT_MARK, EIM_TEMP_MARK, EIM_TEMP_TAIL,
                            EIM_PERM} eim_state_t;
endpackage : eim_pkg

// *** logic/eim_sync_if.sv ***
`timescale 1ns/1ps
// carries the synchronised index mark between the filter and the mode logic
interface eim_sync_if;
  logic mark;
  modport src (output mark);
  modport dst (input mark);
endinterface : eim_sync_if

// *** logic/eim_mark_sync.sv ***
`timescale 1ns/1ps
// three flops; the level changes only once the second and third agree
module eim_mark_sync (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic raw_in,
  eim_sync_if.src sync
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // s1 feeds only s2, to keep metastability contained
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // agreement filter
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      level_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign sync.mark = level_r;
endmodule : eim_mark_sync

// *** verif/eim_host_model.sv ***
`timescale 1ns/1ps
// host side: one command per call, valid for a single cycle
module eim_host_model (
  input wire logic clock_in,
  input wire logic serial_mode_in,
  output logic [7:0] cmd_code_out,
  output logic cmd_valid_out
);
  int timeouts = 0;
  initial begin
    cmd_code_out = 8'h00;
    cmd_valid_out = 1'b0;
  end
  // a polite host holds back until serial mode; wait_serial=0 forces a refused send
  task automatic send(input logic [7:0] code, input bit wait_serial);
    int n;
    n = 0;
    while (wait_serial && serial_mode_in !== 1'b1 && n < 1000) begin
      @(negedge clock_in);
      n++;
    end
    if (wait_serial && serial_mode_in !== 1'b1) begin
      timeouts++; // counted as a mismatch at the end of the run
    end
    @(negedge clock_in);
    cmd_code_out = code;
    cmd_valid_out = 1'b1;
    @(negedge clock_in);
    cmd_valid_out = 1'b0;
    cmd_code_out = ~code; // stale code must not pass as a command
  endtask : send
endmodule : eim_host_model

// *** verif/encoder_index_output_mode_tb.sv ***
`timescale 1ns/1ps
module encoder_index_output_mode_tb;
  localparam int ST = 20;
  localparam int TL = 16;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic index_mark_in = 1'b0;
  logic serial_data_in = 1'b0;
  logic serial_oe_in = 1'b0;
  logic [7:0] cmd_code;
  logic cmd_valid, cmd_accept, line_data, line_oe, index_mode, serial_mode;
  logic [2:0] exp_q[$];
  logic [2:0] seen_r = 3'h0;
  logic [2:0] last_exp = 3'h0;
  logic [31:0] rng = 32'he6d86cf3;
  int fail_count = 0;
  int num_checks = 0;
  always #12.5 clock_in = ~clock_in;
  eim_index_mode #(.START_CYCLES(ST), .TAIL_CYCLES(TL)) i_eim_index_mode (.clock_in(clock_in),
    .reset_in(reset_in), .cmd_code_in(cmd_code), .cmd_valid_in(cmd_valid), .index_mark_in(index_mark_in),
    .serial_data_in(serial_data_in), .serial_oe_in(serial_oe_in), .cmd_accept_out(cmd_accept),
    .line_data_out(line_data), .line_oe_out(line_oe), .index_mode_out(index_mode), .serial_mode_out(serial_mode));
  eim_host_model i_eim_host_model (.clock_in(clock_in), .serial_mode_in(serial_mode), .cmd_code_out(cmd_code),
    .cmd_valid_out(cmd_valid));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // only changes are queued, matching what the watcher can see
  task automatic note(input logic [2:0] v);
    if (v !== last_exp) begin
      exp_q.push_back(v);
      last_exp = v;
    end
  endtask : note
  // watcher: every change of mode or line takes the oldest note; falling edge, where outputs have settled
  always @(negedge clock_in) begin
    if ({index_mode, line_oe, line_data} !== seen_r) begin
      seen_r <= {index_mode, line_oe, line_data};
      if (exp_q.size() == 0) check("line change", {index_mode, line_oe, line_data}, seen_r);
      else check("line state", {index_mode, line_oe, line_data}, exp_q.pop_front());
    end
  end
  task automatic do_index(input logic [7:0] code, input bit temp);
    int n;
    note(3'b100);
    i_eim_host_model.send(code, 1'b1);
    check("accept in index", cmd_accept, 1'b0);
    i_eim_host_model.send(temp ? 8'h5f : 8'h54, 1'b0);
    repeat (ST - 6) @(negedge clock_in);
    check("released in delay", line_oe, 1'b0);
    note(3'b110);
    repeat (6) @(negedge clock_in);
    check("driven after delay", line_oe, 1'b1);
    index_mark_in = 1'b1;
    note(3'b111);
    repeat (8) @(negedge clock_in);
    index_mark_in = 1'b0;
    note(3'b110);
    if (temp) begin
      note(3'b000);
      n = 0;
      while (serial_mode !== 1'b1 && n < TL + 20) begin
        @(negedge clock_in);
        n++;
      end
      check("tail length", n > TL && n <= TL + 8, 1'b1);
      check("accept after tail", cmd_accept, 1'b1);
    end else begin
      repeat (TL + 20) @(negedge clock_in);
      check("perm persists", index_mode, 1'b1);
      note(3'b000);
      reset_in = 1'b1;
      @(negedge clock_in);
      reset_in = 1'b0;
      check("serial after power", serial_mode, 1'b1);
    end
  endtask : do_index
  task automatic wrap_up;
    check("pending notes", exp_q.size(), 0);
    check("host wait timeouts", i_eim_host_model.timeouts, 0);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(negedge clock_in);
    reset_in = 1'b0;
    check("accept after reset", cmd_accept, 1'b1);
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      serial_data_in = rng[0];
      serial_oe_in = rng[1];
      note({1'b0, rng[1], rng[0]});
      @(negedge clock_in);
    end
    serial_data_in = 1'b0;
    serial_oe_in = 1'b0;
    note(3'b000);
    i_eim_host_model.send(8'h30, 1'b1);
    check("other code ignored", index_mode, 1'b0);
    do_index(8'h54, 1'b1);
    do_index(8'h5f, 1'b0);
    repeat (4) @(negedge clock_in);
    wrap_up();
  end
endmodule : encoder_index_output_mode_tb
